// *** ipf_defs.svh ***
// Offsets, field positions, reset values and counts of the priority block
`ifndef IPF_DEFS_SVH
`define IPF_DEFS_SVH

// Register offsets (chosen, byte addresses on the plain port)
`define IPF_OFS_PRIO_A 4'h0
`define IPF_OFS_PRIO_B 4'h1
`define IPF_OFS_FLAGS 4'h2
`define IPF_OFS_SENSE 4'h3
`define IPF_OFS_SOURCE 4'h4

// Reset values
`define IPF_RST_PRIO 8'h00
`define IPF_RST_FLAGS 6'h00
`define IPF_RST_SENSE 6'h00

// Field positions in priority_select_a
`define IPF_A_EXT0 7
`define IPF_A_EXT1 6
`define IPF_A_EXT2_3 5
`define IPF_A_EXT4_5 4
`define IPF_A_WDT_CONV 3
`define IPF_A_WIDE0 2
`define IPF_A_WIDE1 1
`define IPF_A_WIDE2 0

// Field positions in priority_select_b
`define IPF_B_NARROW0_1 7
`define IPF_B_NARROW2_3 6
`define IPF_B_SERIAL0 3
`define IPF_B_SERIAL1 2

// Source count and number of external request pins
`define IPF_NSRC 21
`define IPF_NEXT 6

`endif

// *** ipf_pkg.sv ***
// Types shared by the priority and request flag logic
`default_nettype none
package ipf_pkg;
  typedef logic [7:0] ipf_byte_t;
  typedef logic [4:0] ipf_idx_t;
  typedef logic [20:0] ipf_src_t;
endpackage
`default_nettype wire

// *** ipf_flag.sv ***
// One external request flag with level or falling-edge setting
`default_nettype none
module ipf_flag (
  input wire logic clk_i,    // System clock
  input wire logic rstn_i,   // Async reset, active low
  input wire logic stby_i,   // Hardware standby clear
  input wire logic pin_i,    // Synchronised pin level
  input wire logic sense_i,  // 0 level, 1 falling edge
  input wire logic clr_sw_i, // Software zero write after read
  input wire logic ack_i,    // Exception handling done
  output logic flag_o        // Request flag
);
  import ipf_pkg::*;

  typedef struct packed {
    logic flag;
    logic pin_d;
  } ipf_flag_st_t;

  ipf_flag_st_t st_reg;
  ipf_flag_st_t st_next;
  logic set_ev;
  logic clr_ev;

  // Setting wins over any clear but standby in the same cycle
  always_comb begin
    st_next = st_reg;
    st_next.pin_d = pin_i;
    set_ev = sense_i ? (st_reg.pin_d & ~pin_i) : ~pin_i;
    clr_ev = clr_sw_i
      | (ack_i & sense_i)
      | (ack_i & ~sense_i & pin_i);
    if (stby_i) begin
      st_next.flag = 1'b0;
    end else if (set_ev) begin
      st_next.flag = 1'b1;
    end else if (clr_ev) begin
      st_next.flag = 1'b0;
    end
  end

  // Idle pin is high, so the edge history starts high
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg <= '{flag: 1'b0, pin_d: 1'b1};
    end else begin
      st_reg <= st_next;
    end
  end

  assign flag_o = st_reg.flag;

  chk_edge_sets: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!stby_i && sense_i && st_reg.pin_d && !pin_i) |=> flag_o)
    else $error("falling edge did not set flag");
  chk_sw_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (clr_sw_i && !set_ev) |=> !flag_o)
    else $error("software clear ignored");
endmodule
`default_nettype wire

// *** ipf_ctrl.sv ***
// Interrupt priority select registers, request flags and arbitration
//
// Notes on behaviour
// - Select A bit 7 sets ext0 level
// - Select A bit 6 sets ext1 level
// - Select A bit 5 sets ext2,3 level
// - Select A bit 4 sets ext4,5 level
// - Select A bit 3: watchdog and converter
// - Select A bit 2: wide timer 0
// - Select B bit 7: narrow timers 0,1
// - Select B bit 6: narrow timers 2,3
// - Select B bit 3: serial channel 0
// - Select B bit 2: serial channel 1
// - Select B bits 5,4,1,0 plain storage
// - Both selects clear on reset, standby
// - Flags clear on reset and standby
// - Flag bits 7,6 read zero, ignore writes
// - Flag sets on low level or fall
// - Zero write after reading one clears
// - Level mode: clears on handling, pin high
// - Edge mode: clears on handling
// - Sense 0 level, sense 1 falling edge
// - Same level: smaller vector wins
//
// Design decisions made here: the address map and strobed register access.
`include "ipf_defs.svh"
`default_nettype none
module ipf_ctrl (
  input wire logic clk_i,              // System clock 250 MHz
  input wire logic rstn_i,             // Async reset, active low
  input wire logic stby_i,             // Hardware standby
  input wire logic [3:0] addr_i,       // Register address
  input wire ipf_pkg::ipf_byte_t wdata_i, // Write data
  input wire logic wr_i,               // Write strobe
  input wire logic rd_i,               // Read strobe
  output ipf_pkg::ipf_byte_t rdata_o,  // Read data, one cycle later
  input wire logic [5:0] ext_n_i,      // External request pins, low
  input wire logic [14:0] per_req_i,   // Peripheral request levels
  input wire logic ack_i,              // Exception handling taken
  input wire ipf_pkg::ipf_idx_t ack_idx_i, // Source handled
  output logic req_o,                  // A request is pending
  output ipf_pkg::ipf_idx_t idx_o,     // Winning source index
  output logic lvl_o                   // Winner's priority level
);
  import ipf_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Source index order follows vector order: ext0..5, watchdog,
  // converter, wide timers 0..2 (3 each), narrow timer pairs 0,1 and
  // 2,3 (one line per pair), serial 0 and 1 (lumped, one each).
  typedef struct packed {
    ipf_byte_t prio_a;
    ipf_byte_t prio_b;
    logic [5:0] sense;
    logic [5:0] seen;      // Flags read as one since last clear
    logic [5:0] pin_s1;
    logic [5:0] pin_s2;
    ipf_byte_t rdata;
    logic req;
    ipf_idx_t idx;
    logic lvl;
  } ipf_st_t;

  ipf_st_t st_reg;
  ipf_st_t st_next;
  logic [5:0] flags;
  logic [5:0] clr_sw;
  logic [5:0] ack_ext;
  ipf_src_t pend;
  ipf_src_t lvl_map;
  ipf_src_t hi_pend;
  ipf_src_t use_pend;
  logic found;
  ipf_idx_t win;

  // ----------------------------------------------------------------
  // Request flags, one per external pin
  // ----------------------------------------------------------------
  // Pins come from outside, so the flag logic reads only the second
  // synchroniser stage.
  genvar gi;
  generate
    for (gi = 0; gi < `IPF_NEXT; gi++) begin : g_flag
      assign clr_sw[gi] = wr_i && (addr_i == `IPF_OFS_FLAGS)
        && !wdata_i[gi] && st_reg.seen[gi];
      assign ack_ext[gi] = ack_i && (ack_idx_i == ipf_idx_t'(gi));
      ipf_flag u_flag (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .stby_i(stby_i),
        .pin_i(st_reg.pin_s2[gi]),
        .sense_i(st_reg.sense[gi]),
        .clr_sw_i(clr_sw[gi]),
        .ack_i(ack_ext[gi]),
        .flag_o(flags[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Level of each source from the select registers
  // ----------------------------------------------------------------
  always_comb begin
    lvl_map = '0;
    lvl_map[0] = st_reg.prio_a[`IPF_A_EXT0];
    lvl_map[1] = st_reg.prio_a[`IPF_A_EXT1];
    lvl_map[2] = st_reg.prio_a[`IPF_A_EXT2_3];
    lvl_map[3] = st_reg.prio_a[`IPF_A_EXT2_3];
    lvl_map[4] = st_reg.prio_a[`IPF_A_EXT4_5];
    lvl_map[5] = st_reg.prio_a[`IPF_A_EXT4_5];
    lvl_map[6] = st_reg.prio_a[`IPF_A_WDT_CONV];
    lvl_map[7] = st_reg.prio_a[`IPF_A_WDT_CONV];
    lvl_map[10:8] = {3{st_reg.prio_a[`IPF_A_WIDE0]}};
    lvl_map[13:11] = {3{st_reg.prio_a[`IPF_A_WIDE1]}};
    lvl_map[16:14] = {3{st_reg.prio_a[`IPF_A_WIDE2]}};
    lvl_map[17] = st_reg.prio_b[`IPF_B_NARROW0_1];
    lvl_map[18] = st_reg.prio_b[`IPF_B_NARROW2_3];
    lvl_map[19] = st_reg.prio_b[`IPF_B_SERIAL0];
    lvl_map[20] = st_reg.prio_b[`IPF_B_SERIAL1];
  end

  // ----------------------------------------------------------------
  // Arbitration: level 1 first, then the lowest index
  // ----------------------------------------------------------------
  // Each narrow timer pair has its own slot, so both pair selects
  // steer a source of their own and never share an index.
  always_comb begin
    pend = {per_req_i, flags};
    hi_pend = pend & lvl_map;
    use_pend = (hi_pend != '0) ? hi_pend : pend;
    found = 1'b0;
    win = '0;
    for (int i = 0; i < `IPF_NSRC; i++) begin
      if (!found && use_pend[i]) begin
        found = 1'b1;
        win = ipf_idx_t'(i);
      end
    end
  end

  // ----------------------------------------------------------------
  // Register port and next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.pin_s1 = ext_n_i;
    st_next.pin_s2 = st_reg.pin_s1;
    st_next.rdata = 8'h00;
    st_next.req = found;
    st_next.idx = win;
    st_next.lvl = found && (hi_pend != '0);
    // A read of one arms the later zero write
    if (rd_i && addr_i == `IPF_OFS_FLAGS) begin
      st_next.seen = st_reg.seen | flags;
    end
    st_next.seen = st_next.seen & ~clr_sw & flags;
    if (wr_i) begin
      if (addr_i == `IPF_OFS_PRIO_A) begin
        st_next.prio_a = wdata_i;
      end else if (addr_i == `IPF_OFS_PRIO_B) begin
        st_next.prio_b = wdata_i;
      end else if (addr_i == `IPF_OFS_SENSE) begin
        st_next.sense = wdata_i[5:0];
      end
    end
    if (rd_i) begin
      if (addr_i == `IPF_OFS_PRIO_A) begin
        st_next.rdata = st_reg.prio_a;
      end else if (addr_i == `IPF_OFS_PRIO_B) begin
        st_next.rdata = st_reg.prio_b;
      end else if (addr_i == `IPF_OFS_FLAGS) begin
        st_next.rdata = {2'b00, flags};
      end else if (addr_i == `IPF_OFS_SENSE) begin
        st_next.rdata = {2'b00, st_reg.sense};
      end else if (addr_i == `IPF_OFS_SOURCE) begin
        st_next.rdata = {st_reg.req, st_reg.lvl, 1'b0, st_reg.idx};
      end
    end
    // Standby clears the selects; software can not touch them then
    if (stby_i) begin
      st_next.prio_a = `IPF_RST_PRIO;
      st_next.prio_b = `IPF_RST_PRIO;
      st_next.sense = `IPF_RST_SENSE;
      st_next.seen = `IPF_RST_FLAGS;
    end
  end

  // All state moves on one edge; pins idle high at reset
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg <= '{prio_a: `IPF_RST_PRIO, prio_b: `IPF_RST_PRIO,
                  sense: `IPF_RST_SENSE, seen: `IPF_RST_FLAGS,
                  pin_s1: 6'h3f, pin_s2: 6'h3f, rdata: 8'h00,
                  req: 1'b0, idx: 5'h00, lvl: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata_o = st_reg.rdata;
  assign req_o = st_reg.req;
  assign idx_o = st_reg.idx;
  assign lvl_o = st_reg.lvl;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_flag_top_zero: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $past(rd_i && addr_i == `IPF_OFS_FLAGS) |-> rdata_o[7:6] == 2'b00)
    else $error("reserved flag bits read non-zero");
  chk_prio_a_wr: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (wr_i && addr_i == `IPF_OFS_PRIO_A && !stby_i) ##1
    (rd_i && addr_i == `IPF_OFS_PRIO_A && !stby_i) |=>
    rdata_o == $past(wdata_i, 2))
    else $error("select A did not read back");
  chk_standby_clr: assert property (@(posedge clk_i) disable iff (!rstn_i)
    stby_i |=> st_reg.prio_a == 8'h00 && st_reg.prio_b == 8'h00)
    else $error("standby left a select set");
  chk_one_wr_keeps: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (wr_i && addr_i == `IPF_OFS_FLAGS && wdata_i[0] && flags[0]
     && !stby_i && !ack_ext[0]) |=> flags[0])
    else $error("writing one cleared a flag");
  chk_high_first: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (hi_pend != '0) |=> req_o && lvl_o)
    else $error("level 1 request not favoured");
  chk_low_index: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (hi_pend == '0 && pend[0]) |=> req_o && idx_o == 5'h00)
    else $error("smaller vector not favoured");
  chk_level_set: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!stby_i && !st_reg.sense[1] && !st_reg.pin_s2[1]) |=> flags[1])
    else $error("low level did not set flag");
  chk_edge_ack: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!stby_i && st_reg.sense[2] && ack_ext[2] && st_reg.pin_s2[2])
    |=> !flags[2])
    else $error("handling did not clear edge flag");
  chk_level_ack: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!stby_i && !st_reg.sense[3] && ack_ext[3] && st_reg.pin_s2[3])
    |=> !flags[3])
    else $error("handling did not clear level flag");
  chk_reserved_b: assert property (@(posedge clk_i) disable iff (!rstn_i)
    lvl_map[20:17] == {st_reg.prio_b[`IPF_B_SERIAL1],
    st_reg.prio_b[`IPF_B_SERIAL0], st_reg.prio_b[`IPF_B_NARROW2_3],
    st_reg.prio_b[`IPF_B_NARROW0_1]})
    else $error("reserved select bits steer priority");

  // ----------------------------------------------------------------
  // Lone source checks
  // ----------------------------------------------------------------
  // With a single source pending, the winner must be that source and
  // its level the select bit that was in force one cycle before.

  chk_lone_ext0: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    pend == 21'h000001 |=> idx_o == 5'h00
    && lvl_o == $past(st_reg.prio_a[`IPF_A_EXT0]))
    else $error("ext0 level not from its select bit");

  chk_lone_ext1: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    pend == 21'h000002 |=> idx_o == 5'h01
    && lvl_o == $past(st_reg.prio_a[`IPF_A_EXT1]))
    else $error("ext1 level not from its select bit");

  chk_lone_ext2: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    pend == 21'h000004 |=> idx_o == 5'h02
    && lvl_o == $past(st_reg.prio_a[`IPF_A_EXT2_3]))
    else $error("ext2 level not from its select bit");

  chk_lone_ext4: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    pend == 21'h000010 |=> idx_o == 5'h04
    && lvl_o == $past(st_reg.prio_a[`IPF_A_EXT4_5]))
    else $error("ext4 level not from its select bit");

  chk_lone_wdog: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    pend == 21'h000040 |=> idx_o == 5'h06
    && lvl_o == $past(st_reg.prio_a[`IPF_A_WDT_CONV]))
    else $error("watchdog level not from its select bit");

  chk_lone_wide0: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    pend == 21'h000100 |=> idx_o == 5'h08
    && lvl_o == $past(st_reg.prio_a[`IPF_A_WIDE0]))
    else $error("wide timer 0 level not from its select bit");

  chk_lone_wide1: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    pend == 21'h000800 |=> idx_o == 5'h0b
    && lvl_o == $past(st_reg.prio_a[`IPF_A_WIDE1]))
    else $error("wide timer 1 level not from its select bit");

  chk_lone_wide2: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    pend == 21'h004000 |=> idx_o == 5'h0e
    && lvl_o == $past(st_reg.prio_a[`IPF_A_WIDE2]))
    else $error("wide timer 2 level not from its select bit");

  chk_lone_nar01: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    pend == 21'h020000 |=> idx_o == 5'h11
    && lvl_o == $past(st_reg.prio_b[`IPF_B_NARROW0_1]))
    else $error("narrow pair 0,1 level not from its select bit");

  chk_lone_nar23: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    pend == 21'h040000 |=> idx_o == 5'h12
    && lvl_o == $past(st_reg.prio_b[`IPF_B_NARROW2_3]))
    else $error("narrow pair 2,3 level not from its select bit");

  chk_lone_ser0: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    pend == 21'h080000 |=> idx_o == 5'h13
    && lvl_o == $past(st_reg.prio_b[`IPF_B_SERIAL0]))
    else $error("serial 0 level not from its select bit");

  chk_lone_ser1: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    pend == 21'h100000 |=> idx_o == 5'h14
    && lvl_o == $past(st_reg.prio_b[`IPF_B_SERIAL1]))
    else $error("serial 1 level not from its select bit");

  // Nothing pending must leave the request outputs quiet
  chk_idle_quiet: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    pend == '0 |=> !req_o && !lvl_o)
    else $error("request shown with nothing pending");

  // Read data stand only in the cycle after a read strobe
  chk_rdata_idle: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    !$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data shown without a read");
endmodule
`default_nettype wire

// *** ipf_src_model.sv ***
// Model of the pins, peripheral sources and the core's acknowledge
`default_nettype none
module ipf_src_model (
  input wire logic clk_i,              // System clock
  input wire logic [5:0] pin_low_i,    // Pins to pull low
  input wire logic [14:0] per_i,       // Peripheral requests
  input wire logic ack_go_i,           // Take one exception
  input wire ipf_pkg::ipf_idx_t sel_i, // Source to handle
  output logic [5:0] ext_n_o,          // Pin levels
  output logic [14:0] per_req_o,       // Request levels
  output var logic ack_o,              // Handling pulse
  output ipf_pkg::ipf_idx_t ack_idx_o  // Handled source
);
  import ipf_pkg::*;
  // Pins sit on pull-ups, so a released pin reads high
  assign ext_n_o = ~pin_low_i;
  assign per_req_o = per_i;
  // The core answers one cycle late, one pulse per request
  initial ack_o = 1'b0;
  always @(posedge clk_i) begin
    ack_o <= ack_go_i;
    ack_idx_o <= sel_i;
  end
endmodule
`default_nettype wire

// *** irq_priority_and_flags_tb.sv ***
// Self-checking bench for the priority and request flag block
`default_nettype none
module irq_priority_and_flags_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ipf_pkg::*;
  logic clk_i, rstn_i, stby_i, wr_i, rd_i, ack_i, req_o, lvl_o, ack_go;
  logic [3:0] addr_i;
  ipf_byte_t wdata_i, rdata_o, got;
  logic [5:0] ext_n_i, pin_low;
  logic [14:0] per_req_i, per;
  ipf_idx_t ack_idx_i, idx_o, sel;
  int miscompares, compares;

  ipf_ctrl dut (.clk_i(clk_i), .rstn_i(rstn_i), .stby_i(stby_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .ext_n_i(ext_n_i), .per_req_i(per_req_i),
    .ack_i(ack_i), .ack_idx_i(ack_idx_i), .req_o(req_o), .idx_o(idx_o),
    .lvl_o(lvl_o));
  ipf_src_model far (.clk_i(clk_i), .pin_low_i(pin_low), .per_i(per),
    .ack_go_i(ack_go), .sel_i(sel), .ext_n_o(ext_n_i),
    .per_req_o(per_req_i), .ack_o(ack_i), .ack_idx_o(ack_idx_i));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic complete_run;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    cmp(rdata_o, e);
  endtask
  task automatic ack(input logic [4:0] n);
    @(posedge clk_i);
    ack_go <= 1'b1;
    sel <= n;
    @(posedge clk_i);
    ack_go <= 1'b0;
    tick(4);
  endtask
  task automatic arb(input logic [7:0] id, input logic lv);
    tick(3);
    cmp({7'h0, req_o}, 8'h01);
    cmp({3'h0, idx_o}, id);
    cmp({7'h0, lvl_o}, {7'h0, lv});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rdchk(4'h0, 8'h00);
    rdchk(4'h1, 8'h00);
    rdchk(4'h2, 8'h00);
    rdchk(4'hf, 8'h00);
    wr(4'h1, 8'h33);
    rdchk(4'h1, 8'h33);
  endtask
  // Nine peripheral lines, each alone: its own select bit lifts it, the other bits of its register must not
  task automatic t_periph;
    int b[9] = '{0, 1, 2, 5, 8, 11, 12, 13, 14};
    logic [3:0] r[9] = '{0, 0, 0, 0, 0, 1, 1, 1, 1};
    logic [7:0] m[9] = '{8'h08, 8'h08, 8'h04, 8'h02, 8'h01, 8'h80,
      8'h40, 8'h08, 8'h04};
    for (int i = 0; i < 9; i++) begin
      per <= 15'h0001 << b[i];
      wr(r[i], m[i]);
      tick(3);
      cmp({6'h0, req_o, lvl_o}, 8'h03);
      wr(r[i], ~m[i]);
      tick(3);
      cmp({6'h0, req_o, lvl_o}, 8'h02);
      wr(r[i], 8'h00);
    end
    per <= '0;
  endtask
  task automatic t_ext;
    logic [7:0] m[4] = '{8'h80, 8'h40, 8'h20, 8'h10};
    logic [7:0] w[4] = '{8'h00, 8'h01, 8'h02, 8'h04};
    pin_low <= 6'h3f;
    tick(2);
    arb(8'h00, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, m[i]);
      arb(w[i], 1'b1);
    end
    wr(4'h0, 8'h08);
    per <= 14'h0001;
    tick(3);
    cmp({7'h0, lvl_o}, 8'h01);
    cmp({7'h0, idx_o > 5'd5}, 8'h01);
    per <= '0;
    wr(4'h0, 8'h00);
    rdchk(4'h2, 8'h3f);
    pin_low <= 6'h00;
    ack(5'd2);
    rdchk(4'h2, 8'h3b);
    wr(4'h2, 8'hff);
    rdchk(4'h2, 8'h3b);
    wr(4'h2, 8'h3a);
    rdchk(4'h2, 8'h3a);
    wr(4'h2, 8'h00);
    rdchk(4'h2, 8'h00);
  endtask
  // Edge mode: handling clears even while the pin stays low
  task automatic t_edge;
    wr(4'h3, 8'h3f);
    pin_low <= 6'h20;
    tick(5);
    rdchk(4'h2, 8'h20);
    ack(5'd5);
    rdchk(4'h2, 8'h00);
    pin_low <= 6'h00;
  endtask
  task automatic t_standby;
    wr(4'h0, 8'hff);
    wr(4'h1, 8'hff);
    pin_low <= 6'h01;
    tick(5);
    pin_low <= 6'h00;
    @(posedge clk_i);
    stby_i <= 1'b1;
    @(posedge clk_i);
    stby_i <= 1'b0;
    rdchk(4'h0, 8'h00);
    rdchk(4'h1, 8'h00);
    rdchk(4'h2, 8'h00);
  endtask

  // ----------------------------------------
  // Clock, reset, sequence and watchdog
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    {rstn_i, stby_i, wr_i, rd_i, ack_go} = '0;
    addr_i = '0;
    wdata_i = '0;
    pin_low = '0;
    per = '0;
    sel = '0;
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_periph();
    t_ext();
    t_edge();
    t_standby();
    complete_run();
  end
  // Whole run is well under a thousand cycles; allow generous slack
  initial begin
    #40000;
    miscompares++;
    complete_run();
  end
endmodule
`default_nettype wire
